//--- common/sps_regs.svh
// state and pattern encoding constants for the stepper phase sequencer
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_STATE_ZERO 2'h0
`define SPS_STATE_LAST 2'h3
`define SPS_PAT_S0 4'h5
`define SPS_PAT_S1 4'h9
`define SPS_PAT_S2 4'hA
`define SPS_PAT_S3 4'h6
`endif

//--- common/sps_pkg.sv
// types for the stepper phase sequencer
package sps_pkg;
	typedef logic [1:0] sps_phase_t;
	typedef logic [3:0] sps_pattern_t;
endpackage : sps_pkg

//--- rtl/stepper_phase_sequencer.sv
// four-phase stepping motor sequencer: step edge counter plus code converter
// How it works
// - each step rising edge advances one position
// - two-bit counter, states zero to three, wrapping
// - direction input selects forward or reverse order
// - direction low: LHLH, HLLH, HLHL, LHHL
// - direction high: LHLH, LHHL, HLHL, HLLH
// - clear forces state zero regardless of step
// - clear active low, holds zero pattern
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_stepper_phase_sequencer
	import sps_pkg::*;
(
	// clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	// control pins from outside the clock domain
	input wire logic stepPulse,
	input wire logic directionSel,
	input wire logic clear_n,
	// phase outputs, bit pattern is output one in bit 3
	output logic phase_out_1,
	output logic phase_out_2,
	output logic phase_out_3,
	output logic phase_out_4
);
	// pin synchronisers: the first stage is read only by the second
	logic [2:0] syncA_q, syncA_d;
	logic [2:0] syncB_q, syncB_d;

	// edge detector memory for the synchronised step
	logic stepPrev_q, stepPrev_d;

	// the motor position, four states, free wrap
	sps_phase_t phase_counter_q, phase_counter_d;

	// registered drive pattern, output one in bit 3
	sps_pattern_t pattern_q, pattern_d;

	// decoded views of the second synchroniser stage
	logic advance;
	logic stepSync;
	logic dirSync;
	logic clrSync_n;

	// split the second stage into its three pins
	assign stepSync = syncB_q[0];
	assign dirSync = syncB_q[1];
	assign clrSync_n = syncB_q[2];

	// one strobe per rising edge of the synchronised step
	// the detector reads only the second stage, so a metastable first stage never reaches it
	assign advance = stepSync & ~stepPrev_q;

	// synchroniser next values: every pin gets the same two-stage delay,
	// so direction and clear keep their order relative to the step edge
	always_comb begin
		syncA_d = {clear_n, directionSel, stepPulse};
		syncB_d = syncA_q;
	end

	// synchroniser registers; the clear stage resets inactive,
	// so the release of reset never looks like a clear request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= 3'h4;
			syncB_q <= 3'h4;
		end else if (clockEnable) begin
			syncA_q <= syncA_d;
			syncB_q <= syncB_d;
		end
	end

	// edge detector next value: remembers the last synchronised step level
	always_comb begin
		stepPrev_d = stepSync;
	end

	// edge detector register; resets to the idle low level of the step pin,
	// which avoids a false advance just after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stepPrev_q <= 1'h0;
		end else if (clockEnable) begin
			stepPrev_q <= stepPrev_d;
		end
	end

	// counter next value; clear wins over a simultaneous step edge,
	// so a pulse that arrives during clear is lost, not deferred
	always_comb begin
		phase_counter_d = phase_counter_q;
		if (!clrSync_n) begin
			phase_counter_d = `SPS_STATE_ZERO;
		end else if (advance) begin
			// natural 2-bit wrap from last back to zero
			phase_counter_d = phase_counter_q + 2'h1;
		end
	end

	// counter register; counting order is the same in both directions,
	// the direction only changes how a state is decoded
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_counter_q <= `SPS_STATE_ZERO;
		end else if (clockEnable) begin
			phase_counter_q <= phase_counter_d;
		end
	end

	// code converter; decodes the next state so outputs follow the edge in one cycle
	// limitation: a direction change re-decodes the present state at once,
	// so the motor may jump two positions if direction flips mid-run
	always_comb begin
		unique case (phase_counter_d)
			2'h0: pattern_d = `SPS_PAT_S0;
			2'h1: pattern_d = dirSync ? `SPS_PAT_S3 : `SPS_PAT_S1;
			2'h2: pattern_d = `SPS_PAT_S2;
			2'h3: pattern_d = dirSync ? `SPS_PAT_S1 : `SPS_PAT_S3;
		endcase
	end

	// pattern register; resets to the state-zero pattern, which both directions share
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pattern_q <= `SPS_PAT_S0;
		end else if (clockEnable) begin
			pattern_q <= pattern_d;
		end
	end

	// outputs straight from the pattern register, no logic after the flops
	assign phase_out_1 = pattern_q[3];
	assign phase_out_2 = pattern_q[2];
	assign phase_out_3 = pattern_q[1];
	assign phase_out_4 = pattern_q[0];

	// checks: counting
	AST_ADVANCE: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && advance && clrSync_n |=> phase_counter_q == $past(phase_counter_q) + 2'h1)
		else $error("step edge did not advance counter");
	AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
		clrSync_n && !advance |=> $stable(phase_counter_q))
		else $error("counter moved without step edge");
	AST_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && advance && clrSync_n && phase_counter_q == 2'h3 |=> phase_counter_q == 2'h0)
		else $error("counter did not wrap");

	// checks: clear
	AST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && !clrSync_n |=> phase_counter_q == `SPS_STATE_ZERO && pattern_q == `SPS_PAT_S0)
		else $error("clear did not force state zero");
	AST_CLEARPIN: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && !clear_n [*4] |-> phase_counter_q == 2'h0)
		else $error("low clear pin not holding zero");
	AST_CLEAR_STEP: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && !clrSync_n && advance |=> phase_counter_q == `SPS_STATE_ZERO)
		else $error("step edge beat the clear");

	// checks: code converter, forward order
	AST_FWD: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && !dirSync && phase_counter_d == 2'h1 |=> pattern_q == `SPS_PAT_S1)
		else $error("forward state one pattern wrong");
	AST_FWD3: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && !dirSync && phase_counter_d == 2'h3 |=> pattern_q == `SPS_PAT_S3)
		else $error("forward state three pattern wrong");

	// checks: code converter, reverse order
	AST_REV: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && dirSync && phase_counter_d == 2'h3 |=> pattern_q == `SPS_PAT_S1)
		else $error("reverse state three pattern wrong");
	AST_REV1: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && dirSync && phase_counter_d == 2'h1 |=> pattern_q == `SPS_PAT_S3)
		else $error("reverse state one pattern wrong");

	// checks: states shared by both directions, and state one against the direction select
	AST_S0_PAT: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && phase_counter_d == 2'h0 |=> pattern_q == `SPS_PAT_S0)
		else $error("state zero pattern wrong");
	AST_S2_PAT: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && phase_counter_d == 2'h2 |=> pattern_q == `SPS_PAT_S2)
		else $error("state two pattern wrong");
	AST_DIR: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && phase_counter_d == 2'h1 |=> pattern_q == ($past(dirSync) ? 4'h6 : 4'h9))
		else $error("direction select ignored");

	// checks: step strobe and enable
	AST_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
		advance && clockEnable |=> !advance)
		else $error("advance strobe longer than one cycle");
	AST_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
		!clockEnable |=> $stable(phase_counter_q) && $stable(pattern_q) && $stable(syncB_q))
		else $error("state moved while enable low");

	// main scenarios to be reached
	COV_FWD_WRAP: cover property (@(posedge clock) disable iff (!rst_n)
		advance && !dirSync && phase_counter_q == 2'h3);
	COV_REV_STEP: cover property (@(posedge clock) disable iff (!rst_n) advance && dirSync);
	COV_CLEAR: cover property (@(posedge clock) disable iff (!rst_n) !clrSync_n && phase_counter_q != 2'h0);
	COV_CLEAR_STEP: cover property (@(posedge clock) disable iff (!rst_n) !clrSync_n && advance);
	COV_FREEZE: cover property (@(posedge clock) disable iff (!rst_n) !clockEnable && stepPulse);
endmodule : sps_stepper_phase_sequencer

//--- test/sps_step_source.sv
// step pulse source model for the stepper phase sequencer
`timescale 1ns/1ps
module sps_step_source (
	// clock and request
	input wire logic clock,
	input wire logic fire,
	// step pin
	output logic stepPulse
);
	// four cycles high then four low, wide enough for the two-flop synchroniser
	int cnt = 0;
	always @(posedge clock) begin
		if (fire) cnt <= 8;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	assign stepPulse = (cnt > 4);
endmodule : sps_step_source

//--- test/test_stepper_phase_sequencer.sv
// testbench for the stepper phase sequencer
`timescale 1ns/1ps
`include "sps_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_stepper_phase_sequencer;
	import sps_pkg::*;
	logic clock = 0, rst_n = 0, directionSel = 0, clear_n = 1, fire = 0, clockEnable = 1;
	logic stepPulse, phase_out_1, phase_out_2, phase_out_3, phase_out_4;
	int num_errors = 0, n_compared = 0, st = 0;
	sps_pattern_t tbl [4] = '{`SPS_PAT_S0, `SPS_PAT_S1, `SPS_PAT_S2, `SPS_PAT_S3};
	wire sps_pattern_t outs = {phase_out_1, phase_out_2, phase_out_3, phase_out_4};
	always #4 clock = ~clock;
	sps_stepper_phase_sequencer u_sps_stepper_phase_sequencer (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
		.stepPulse(stepPulse), .directionSel(directionSel), .clear_n(clear_n), .phase_out_1(phase_out_1),
		.phase_out_2(phase_out_2), .phase_out_3(phase_out_3), .phase_out_4(phase_out_4));
	sps_step_source u_sps_step_source (.clock(clock), .fire(fire), .stepPulse(stepPulse));
	// reverse order walks the forward table backwards
	function automatic sps_pattern_t pat(input int s);
		return tbl[directionSel ? (4 - s) % 4 : s];
	endfunction : pat
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wait_cyc
	// one pulse per step, then judge the pattern long after the sync delay
	task automatic step_run(input logic dir, input int n);
		directionSel = dir;
		wait_cyc(4);
		`CHK("dir", pat(st), outs)
		for (int i = 0; i < n; i++) begin
			fire = 1;
			wait_cyc(1);
			fire = 0;
			wait_cyc(9);
			st = (st + 1) % 4;
			`CHK("phase", pat(st), outs)
		end
	endtask : step_run
	// a step arriving while clear is low must be lost
	task automatic clear_run();
		clear_n = 0;
		fire = 1;
		wait_cyc(1);
		fire = 0;
		wait_cyc(9);
		st = 0;
		`CHK("clear", pat(0), outs)
		clear_n = 1;
		wait_cyc(4);
	endtask : clear_run
	// enable low freezes everything, so the frozen synchroniser loses the pulse
	task automatic freeze_run();
		clockEnable = 0;
		fire = 1;
		wait_cyc(1);
		fire = 0;
		wait_cyc(9);
		`CHK("freeze", pat(st), outs)
		clockEnable = 1;
		wait_cyc(4);
		`CHK("thaw", pat(st), outs)
	endtask : freeze_run
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	initial begin
		wait_cyc(4);
		rst_n = 1;
		`CHK("reset", pat(0), outs)
		step_run(0, 5);
		step_run(1, 6);
		clear_run();
		step_run(1, 2);
		freeze_run();
		finish_test();
	end
	// watchdog well beyond the 174 cycles the run needs
	initial begin
		#20000;
		num_errors++;
		finish_test();
	end
endmodule : test_stepper_phase_sequencer
